// file: src/licb_pkg.sv
// Contract
// (RULE1) Custom driver: square wave or open-drain
// (RULE2) Software keeps custom driver bit zero
// (RULE3) E1 limiter enabled unless disable bit
// (RULE4) Composite filter bit enables 64kHz PLL
// (RULE5) Software sets clock selects and prescalers
// (RULE6) High clock select enables conversion PLL
// (RULE7) Alarm bit zero sends unframed ones
// (RULE8) Composite mode alarm zero drops subrates
// (RULE9) Rising violation bit inserts one violation
// (RULE10) Software clears then sets for another
// (RULE11) Rising reset bit pulses line reset
// (RULE12) Software clears reset bit before resetting
// (RULE13) Pattern bit sends alternating ones zeros
// (RULE14) Monitor field selects gain boost
// (RULE15) Resistor bit selects 120 or 133 ohm
// (RULE16) Termination field picks internal termination
// (RULE17) Invert bit inverts CMI both directions
// (RULE18) CMI enable bit selects CMI mode
// (RULE19) Software writes zero to unused bits
// (RULE20) Software picks clock source per master clock
// (RULE21) Reset zero; hardware mode follows pins
// (RULE22) Rising edges give single-cycle pulses
package licb_pkg;

  // Register offsets and reset value
  localparam logic [7:0] LICB_ADDR_DRIVER_JITTER = 8'h31;
  localparam logic [7:0] LICB_ADDR_CMI_MONITOR   = 8'h32;
  localparam logic [7:0] LICB_ADDR_TERM_PRESCALE = 8'h33;
  localparam logic [7:0] LICB_RESET_VALUE        = 8'h00;
  localparam logic [7:0] LICB_CMI_MONITOR_MASK   = 8'hF9;

  // Driver and jitter register fields
  localparam int unsigned LICB_CUSTOM_DRIVER_BIT = 0;
  localparam int unsigned LICB_LIMITER_DIS_BIT   = 1;
  localparam int unsigned LICB_RX_FILTER_BIT     = 2;
  localparam int unsigned LICB_JCLK_LO_BIT       = 3;
  localparam int unsigned LICB_TX_ALARM_BIT      = 4;
  localparam int unsigned LICB_VIOL_INSERT_BIT   = 5;
  localparam int unsigned LICB_LINE_RESET_BIT    = 6;
  localparam int unsigned LICB_JCLK_HI_BIT       = 7;

  // CMI and monitor register fields
  localparam int unsigned LICB_ALT_PATTERN_BIT   = 0;
  localparam int unsigned LICB_GAIN_LSB          = 3;
  localparam int unsigned LICB_EXT_RES_BIT       = 5;
  localparam int unsigned LICB_CMI_INVERT_BIT    = 6;
  localparam int unsigned LICB_CMI_ENABLE_BIT    = 7;

  // Termination and prescale register fields
  localparam int unsigned LICB_RX_TERM_LSB       = 0;
  localparam int unsigned LICB_TX_TERM_LSB       = 3;
  localparam int unsigned LICB_PRESCALE_LSB      = 6;

  // Termination values in ohms
  localparam logic [7:0] LICB_OHM_NONE = 8'h00;
  localparam logic [7:0] LICB_OHM_75   = 8'h4B;
  localparam logic [7:0] LICB_OHM_100  = 8'h64;
  localparam logic [7:0] LICB_OHM_120  = 8'h78;
  localparam logic [7:0] LICB_OHM_110  = 8'h6E;
  localparam logic [7:0] LICB_OHM_133  = 8'h85;

  // Gain boost in dB
  localparam logic [5:0] LICB_GAIN_DB_0  = 6'h00;
  localparam logic [5:0] LICB_GAIN_DB_20 = 6'h14;
  localparam logic [5:0] LICB_GAIN_DB_26 = 6'h1A;
  localparam logic [5:0] LICB_GAIN_DB_32 = 6'h20;

  typedef struct packed {
    logic       square_wave;
    logic       open_drain;
    logic       limiter_en;
    logic       all_ones_unframed;
    logic       all_ones_no_subrates;
    logic       alt_pattern;
    logic       cmi_enable;
    logic       cmi_invert;
    logic       term_en;
    logic [7:0] term_ohms;
  } licb_tx_s;

  typedef struct packed {
    logic       composite_filter_en;
    logic [5:0] gain_boost_db;
    logic       ext_res_133;
    logic       term_internal;
    logic [7:0] term_ohms;
  } licb_rx_s;

  typedef struct packed {
    logic       conv_pll_en;
    logic [1:0] jitter_clk_select;
    logic [1:0] mclk_prescale;
  } licb_clk_s;

  // Termination code to ohms, zero for codes that select none
  function automatic logic [7:0] licb_term_ohms(input logic [2:0] code);
    unique case (code)
      3'h1:    return LICB_OHM_75;
      3'h2:    return LICB_OHM_100;
      3'h3:    return LICB_OHM_120;
      3'h4:    return LICB_OHM_110;
      3'h5:    return LICB_OHM_133;
      default: return LICB_OHM_NONE;
    endcase
  endfunction : licb_term_ohms

endpackage : licb_pkg

// file: src/licb_rise_pulse.sv
`timescale 1ns/1ps
module licb_rise_pulse #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // Levels in, pulses out
  input  wire logic [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] pulse
);
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] pulse_q;

  // (RULE22) compare with previous cycle
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      prev_q  <= '0;
      pulse_q <= '0;
    end
    else
    begin
      prev_q  <= level;
      pulse_q <= level & ~prev_q;
    end
  end

  assign pulse = pulse_q;

endmodule : licb_rise_pulse

// file: src/licb_bpv_insert.sv
`timescale 1ns/1ps
module licb_bpv_insert (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Arm request
  input  wire logic arm,
  // Transmit bit stream
  input  wire logic bit_valid,
  input  wire logic bit_in,
  // Insert the previous cycle's bit as a violation
  output logic      violation
);
  import licb_pkg::*;

  typedef enum logic [1:0] {
    LICB_BPV_IDLE  = 2'b01,
    LICB_BPV_ARMED = 2'b10
  } licb_bpv_e;

  licb_bpv_e  state_q;
  logic [1:0] ones_q;
  logic       third_one;
  logic       viol_q;

  assign third_one = bit_valid & bit_in & (ones_q == 2'd2);

  // Run of consecutive ones, saturating at two
  always_ff @(posedge clk)
  begin
    if (reset)
      ones_q <= 2'd0;
    else if (bit_valid)
      ones_q <= bit_in ? ((ones_q == 2'd2) ? 2'd2 : ones_q + 2'd1) : 2'd0;
  end

  // (RULE9) one violation per arm
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= LICB_BPV_IDLE;
      viol_q  <= 1'b0;
    end
    else
    begin
      viol_q <= (state_q == LICB_BPV_ARMED) & third_one;
      unique case (state_q)
        LICB_BPV_IDLE:
          if (arm)
            state_q <= LICB_BPV_ARMED;
        LICB_BPV_ARMED:
          if (third_one && !arm)
            state_q <= LICB_BPV_IDLE;
        default:
          state_q <= LICB_BPV_IDLE;
      endcase
    end
  end

  assign violation = viol_q;

endmodule : licb_bpv_insert

// file: src/licb_line_ctrl.sv
`timescale 1ns/1ps
module licb_line_ctrl (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Parallel control port
  input  wire logic                cpu_cs,
  input  wire logic                cpu_wr,
  input  wire logic                cpu_rd,
  input  wire logic [7:0]          cpu_addr,
  input  wire logic [7:0]          cpu_wdata,
  output logic      [7:0]          cpu_rdata,
  // Hardware control mode pins
  input  wire logic                hw_mode,
  input  wire logic                hw_tx_alarm_pin,
  input  wire logic                hw_jitter_clk_lo_pin,
  input  wire logic [1:0]          hw_mclk_prescale_pin,
  // Line mode context
  input  wire logic [2:0]          line_ctrl_buildout,
  input  wire logic                e1_mode,
  input  wire logic                composite_clock_mode,
  // Transmit bit stream
  input  wire logic                tx_bit_valid,
  input  wire logic                tx_bit,
  output logic                     tx_violation,
  // CMI coded paths
  input  wire logic                cmi_tx_in,
  output logic                     cmi_tx_out,
  input  wire logic                cmi_rx_in,
  output logic                     cmi_rx_out,
  // Decoded controls
  output licb_pkg::licb_tx_s       tx_ctrl,
  output licb_pkg::licb_rx_s       rx_ctrl,
  output licb_pkg::licb_clk_s      clk_ctrl,
  output logic                     line_iface_reset_pulse
);
  import licb_pkg::*;

  logic [7:0] drv_q;
  logic [7:0] cmi_q;
  logic [7:0] term_q;
  logic [7:0] drv_eff;
  logic [7:0] cmi_eff;
  logic [7:0] term_eff;
  logic [7:0] rdata_q;
  logic       wr_hit;
  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [1:0] edge_pulse;
  licb_tx_s   tx_d;
  licb_tx_s   tx_q;
  licb_rx_s   rx_d;
  licb_rx_s   rx_q;
  licb_clk_s  clk_d;
  licb_clk_s  clk_q;
  logic       cmi_tx_q;
  logic       cmi_rx_q;

  // One-hot register select from an address
  function automatic logic [2:0] reg_select(input logic [7:0] addr);
    logic [2:0] sel;
    sel[0] = (addr == LICB_ADDR_DRIVER_JITTER);
    sel[1] = (addr == LICB_ADDR_CMI_MONITOR);
    sel[2] = (addr == LICB_ADDR_TERM_PRESCALE);
    return sel;
  endfunction : reg_select

  // Software writes are ignored in hardware mode
  assign wr_hit = cpu_cs & cpu_wr & ~hw_mode;
  assign wr_sel = reg_select(cpu_addr) & {3{wr_hit}};
  assign rd_sel = reg_select(cpu_addr) & {3{cpu_cs & cpu_rd}};

  // (RULE21) driver register resets to zero
  always_ff @(posedge clk)
  begin
    if (reset)
      drv_q <= LICB_RESET_VALUE;
    else if (wr_sel[0])
      drv_q <= cpu_wdata;
  end

  // (RULE21) CMI register, unused bits zero
  always_ff @(posedge clk)
  begin
    if (reset)
      cmi_q <= LICB_RESET_VALUE;
    else if (wr_sel[1])
      cmi_q <= cpu_wdata & LICB_CMI_MONITOR_MASK;
  end

  // (RULE21) termination register resets to zero
  always_ff @(posedge clk)
  begin
    if (reset)
      term_q <= LICB_RESET_VALUE;
    else if (wr_sel[2])
      term_q <= cpu_wdata;
  end

  // (RULE21) hardware mode follows pins
  always_comb
  begin
    drv_eff  = drv_q;
    cmi_eff  = cmi_q;
    term_eff = term_q;
    if (hw_mode)
    begin
      drv_eff                    = LICB_RESET_VALUE;
      drv_eff[LICB_TX_ALARM_BIT] = hw_tx_alarm_pin;
      drv_eff[LICB_JCLK_LO_BIT]  = hw_jitter_clk_lo_pin;
      cmi_eff                    = LICB_RESET_VALUE;
      term_eff                   = LICB_RESET_VALUE;
      term_eff[LICB_PRESCALE_LSB +: 2] = hw_mclk_prescale_pin;
    end
  end

  // Registered read data, unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_q <= LICB_RESET_VALUE;
    else if (cpu_cs && cpu_rd)
      rdata_q <= ({8{rd_sel[0]}} & drv_eff) | ({8{rd_sel[1]}} & cmi_eff)
                 | ({8{rd_sel[2]}} & term_eff);
  end

  assign cpu_rdata = rdata_q;

  // (RULE22) edge pulses for strobe bits
  licb_rise_pulse #(
    .WIDTH (2)
  ) u_rise (
    .clk   (clk),
    .reset (reset),
    .level ({drv_eff[LICB_LINE_RESET_BIT], drv_eff[LICB_VIOL_INSERT_BIT]}),
    .pulse (edge_pulse)
  );

  // (RULE11) line reset pulse
  assign line_iface_reset_pulse = edge_pulse[1];

  // (RULE9) arm violation on rising edge
  licb_bpv_insert u_bpv (
    .clk       (clk),
    .reset     (reset),
    .arm       (edge_pulse[0]),
    .bit_valid (tx_bit_valid),
    .bit_in    (tx_bit),
    .violation (tx_violation)
  );

  // Transmit side decode
  always_comb
  begin
    tx_d = '0;
    // (RULE1) square wave or open drain
    tx_d.square_wave = drv_eff[LICB_CUSTOM_DRIVER_BIT] & (line_ctrl_buildout == 3'h0);
    tx_d.open_drain  = drv_eff[LICB_CUSTOM_DRIVER_BIT] & (line_ctrl_buildout != 3'h0);
    // (RULE3) limiter only disabled in E1
    tx_d.limiter_en = ~(e1_mode & drv_eff[LICB_LIMITER_DIS_BIT]);
    // (RULE7) unframed all ones
    tx_d.all_ones_unframed = ~composite_clock_mode & ~drv_eff[LICB_TX_ALARM_BIT];
    // (RULE8) all ones without subrates
    tx_d.all_ones_no_subrates = composite_clock_mode & ~drv_eff[LICB_TX_ALARM_BIT];
    // (RULE13) alternating pattern
    tx_d.alt_pattern = cmi_eff[LICB_ALT_PATTERN_BIT];
    // (RULE18) CMI mode select
    tx_d.cmi_enable = cmi_eff[LICB_CMI_ENABLE_BIT];
    tx_d.cmi_invert = cmi_eff[LICB_CMI_INVERT_BIT];
    tx_d.term_ohms  = licb_term_ohms(term_eff[LICB_TX_TERM_LSB +: 3]);
    tx_d.term_en    = (tx_d.term_ohms != LICB_OHM_NONE);
  end

  // Receive side decode
  always_comb
  begin
    logic [7:0] ext_ohms;
    logic [7:0] code_ohms;
    ext_ohms  = LICB_OHM_120;
    code_ohms = LICB_OHM_NONE;
    rx_d      = '0;
    // (RULE4) composite filter only in that mode
    rx_d.composite_filter_en = composite_clock_mode & drv_eff[LICB_RX_FILTER_BIT];
    // (RULE14) gain boost in T1 or E1
    if (!composite_clock_mode)
    begin
      unique case (cmi_eff[LICB_GAIN_LSB +: 2])
        2'h0: rx_d.gain_boost_db = LICB_GAIN_DB_0;
        2'h1: rx_d.gain_boost_db = LICB_GAIN_DB_20;
        2'h2: rx_d.gain_boost_db = LICB_GAIN_DB_26;
        2'h3: rx_d.gain_boost_db = LICB_GAIN_DB_32;
      endcase
    end
    // (RULE15) fitted resistor value
    rx_d.ext_res_133 = cmi_eff[LICB_EXT_RES_BIT];
    ext_ohms = rx_d.ext_res_133 ? LICB_OHM_133 : LICB_OHM_120;
    // (RULE16) 133 needs the 133 resistor
    code_ohms = licb_term_ohms(term_eff[LICB_RX_TERM_LSB +: 3]);
    if (code_ohms == LICB_OHM_NONE || (code_ohms == LICB_OHM_133 && !rx_d.ext_res_133))
      rx_d.term_ohms = ext_ohms;
    else
      rx_d.term_ohms = code_ohms;
    rx_d.term_internal = (rx_d.term_ohms != ext_ohms);
  end

  // Attenuator clock source
  always_comb
  begin
    clk_d = '0;
    // (RULE6) conversion PLL enable
    clk_d.conv_pll_en       = drv_eff[LICB_JCLK_HI_BIT];
    clk_d.jitter_clk_select = {drv_eff[LICB_JCLK_HI_BIT], drv_eff[LICB_JCLK_LO_BIT]};
    clk_d.mclk_prescale     = term_eff[LICB_PRESCALE_LSB +: 2];
  end

  // Registered control outputs
  always_ff @(posedge clk)
  begin
    if (reset)
      tx_q <= '0;
    else
      tx_q <= tx_d;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rx_q <= '0;
    else
      rx_q <= rx_d;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      clk_q <= '0;
    else
      clk_q <= clk_d;
  end

  // (RULE17) transmit CMI inversion
  always_ff @(posedge clk)
  begin
    if (reset)
      cmi_tx_q <= 1'b0;
    else
      cmi_tx_q <= cmi_tx_in ^ (tx_d.cmi_enable & tx_d.cmi_invert);
  end

  // (RULE17) receive CMI inversion
  always_ff @(posedge clk)
  begin
    if (reset)
      cmi_rx_q <= 1'b0;
    else
      cmi_rx_q <= cmi_rx_in ^ (tx_d.cmi_enable & tx_d.cmi_invert);
  end

  assign tx_ctrl    = tx_q;
  assign rx_ctrl    = rx_q;
  assign clk_ctrl   = clk_q;
  assign cmi_tx_out = cmi_tx_q;
  assign cmi_rx_out = cmi_rx_q;

endmodule : licb_line_ctrl

// file: dv/licb_line_model.sv
`timescale 1ns/1ps
module licb_line_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Stream shape
  input  wire logic slow,
  input  wire logic marks_only,
  // Line bits
  output logic      tx_bit_valid,
  output logic      tx_bit,
  output logic      cmi_rx_in
);
  logic [15:0] lfsr_q;

  // Bits update every cycle, valid or not; marks_only holds tx_bit at one
  always_ff @(posedge clk)
  begin
    lfsr_q       <= reset ? 16'hACE1 : {lfsr_q[14:0], ^(lfsr_q & 16'hB400)};
    tx_bit_valid <= !reset && (!slow || !tx_bit_valid);
    tx_bit       <= marks_only | lfsr_q[0];
    cmi_rx_in    <= lfsr_q[3];
  end
endmodule : licb_line_model

// file: dv/licb_line_ctrl_checker.sv
`timescale 1ns/1ps
module licb_line_ctrl_checker (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset,
  // Causes
  input wire logic                cpu_cs,
  input wire logic                cpu_wr,
  input wire logic [7:0]          cpu_addr,
  input wire logic [7:0]          cpu_wdata,
  input wire logic                hw_mode,
  input wire logic                hw_tx_alarm_pin,
  input wire logic                hw_jitter_clk_lo_pin,
  input wire logic [1:0]          hw_mclk_prescale_pin,
  input wire logic [2:0]          line_ctrl_buildout,
  input wire logic                e1_mode,
  input wire logic                composite_clock_mode,
  input wire logic                tx_bit_valid,
  input wire logic                tx_bit,
  input wire logic                cmi_tx_in,
  // Effects
  input wire logic                cmi_tx_out,
  input wire logic                tx_violation,
  input wire licb_pkg::licb_tx_s  tx_ctrl,
  input wire licb_pkg::licb_rx_s  rx_ctrl,
  input wire licb_pkg::licb_clk_s clk_ctrl,
  input wire logic                line_iface_reset_pulse
);
  import licb_pkg::*;
  localparam logic [5:0] GAIN [4] = '{LICB_GAIN_DB_0, LICB_GAIN_DB_20, LICB_GAIN_DB_26,
                                      LICB_GAIN_DB_32};
  logic       wr, pe1_q, pcc_q, pin_q, live_q;
  logic [2:0] pbo_q;
  logic [7:0] r31_q, r32_q, r33_q, e31, e32, e33, p31_q, p32_q, p33_q;
  assign wr  = cpu_cs && cpu_wr && !hw_mode;
  assign e31 = hw_mode ? {3'h0, hw_tx_alarm_pin, hw_jitter_clk_lo_pin, 3'h0} : r31_q;
  assign e32 = hw_mode ? 8'h00 : r32_q;
  assign e33 = hw_mode ? {hw_mclk_prescale_pin, 6'h00} : r33_q;

  // Shadow of software registers
  always_ff @(posedge clk)
  begin
    r31_q <= reset ? 8'h00 : (wr && cpu_addr == 8'h31) ? cpu_wdata : r31_q;
    r32_q <= reset ? 8'h00 : (wr && cpu_addr == 8'h32) ? cpu_wdata & LICB_CMI_MONITOR_MASK : r32_q;
    r33_q <= reset ? 8'h00 : (wr && cpu_addr == 8'h33) ? cpu_wdata : r33_q;
  end

  // Causes as seen by the registered decode
  always_ff @(posedge clk)
  begin
    {p31_q, p32_q, p33_q, pbo_q} <= {e31, e32, e33, line_ctrl_buildout};
    {pe1_q, pcc_q, pin_q, live_q} <= {e1_mode, composite_clock_mode, cmi_tx_in, !reset};
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  property p_drv; live_q |-> tx_ctrl.square_wave == (p31_q[0] && pbo_q == 3'h0)
    && tx_ctrl.open_drain == (p31_q[0] && pbo_q != 3'h0); endproperty
  a_drv: assert property (p_drv) else $error("driver shape wrong");
  property p_lim; live_q |-> tx_ctrl.limiter_en == !(pe1_q && p31_q[1])
    && rx_ctrl.composite_filter_en == (pcc_q && p31_q[2]); endproperty
  a_lim: assert property (p_lim) else $error("limiter or filter wrong");
  property p_clk; live_q |-> clk_ctrl == {p31_q[7], p31_q[7], p31_q[3], p33_q[7:6]}; endproperty
  a_clk: assert property (p_clk) else $error("clock select wrong");
  property p_alarm; live_q |-> tx_ctrl.all_ones_unframed == (!p31_q[4] && !pcc_q)
    && tx_ctrl.all_ones_no_subrates == (!p31_q[4] && pcc_q) && tx_ctrl.alt_pattern == p32_q[0];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm decode wrong");
  property p_gain; live_q |-> rx_ctrl.gain_boost_db == (pcc_q ? 6'h00 : GAIN[p32_q[4:3]]);
  endproperty
  a_gain: assert property (p_gain) else $error("gain boost wrong");
  property p_cmi; live_q |-> cmi_tx_out == (pin_q ^ (p32_q[7] & p32_q[6]))
    && tx_ctrl.cmi_enable == p32_q[7]; endproperty
  a_cmi: assert property (p_cmi) else $error("cmi path wrong");
  property p_rst; wr && cpu_addr == 8'h31 && cpu_wdata[6] && !r31_q[6]
    |-> ##2 line_iface_reset_pulse; endproperty
  a_rst: assert property (p_rst) else $error("line reset missing");
  property p_pulse; line_iface_reset_pulse |=> !line_iface_reset_pulse; endproperty
  a_pulse: assert property (p_pulse) else $error("line reset too long");
  property p_viol; tx_violation |-> $past(tx_bit_valid & tx_bit) && !$past(tx_violation);
  endproperty
  a_viol: assert property (p_viol) else $error("violation misplaced");
endmodule : licb_line_ctrl_checker

bind licb_line_ctrl licb_line_ctrl_checker i_licb_line_ctrl_checker (.*);

// file: dv/test_line_interface_control_bank.sv
`timescale 1ns/1ps
module test_line_interface_control_bank;
  import licb_pkg::*;
  localparam logic [7:0] OHM [8] = '{8'h00, LICB_OHM_75, LICB_OHM_100, LICB_OHM_120,
                                     LICB_OHM_110, LICB_OHM_133, 8'h00, 8'h00};
  localparam logic [5:0] GAIN [4] = '{LICB_GAIN_DB_0, LICB_GAIN_DB_20, LICB_GAIN_DB_26,
                                      LICB_GAIN_DB_32};
  logic        clk = 1'b0, reset = 1'b1, cpu_cs = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
  logic        hw_mode = 1'b0, hw_tx_alarm_pin = 1'b0, hw_jitter_clk_lo_pin = 1'b0;
  logic        e1_mode = 1'b0, composite_clock_mode = 1'b0, cmi_tx_in = 1'b0;
  logic        slow = 1'b0, marks_only = 1'b0, rx_prev = 1'b0, tx_prev = 1'b0;
  logic        tx_bit_valid, tx_bit, tx_violation, cmi_tx_out, cmi_rx_in, cmi_rx_out;
  logic        line_iface_reset_pulse;
  logic [1:0]  hw_mclk_prescale_pin = 2'h0;
  logic [2:0]  line_ctrl_buildout = 3'h0;
  logic [7:0]  cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata, ad;
  logic [7:0]  m31 = 8'h00, m32 = 8'h00, m33 = 8'h00;
  logic [31:0] seed = 32'h0001_061F, v;
  licb_tx_s    tx_ctrl;
  licb_rx_s    rx_ctrl;
  licb_clk_s   clk_ctrl;
  int          fail_count = 0, comparisons = 0, cycles = 0;

  licb_line_ctrl i_licb_line_ctrl (.*);
  licb_line_model i_licb_line_model (.*);

  initial forever #20 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Register value as software should see it
  function automatic logic [7:0] eff(input logic [7:0] a);
    if (hw_mode)
      return a == 8'h31 ? {3'h0, hw_tx_alarm_pin, hw_jitter_clk_lo_pin, 3'h0} :
             a == 8'h33 ? {hw_mclk_prescale_pin, 6'h00} : 8'h00;
    return a == 8'h31 ? m31 : a == 8'h32 ? m32 : a == 8'h33 ? m33 : 8'h00;
  endfunction : eff

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {cpu_cs, cpu_wr, cpu_addr, cpu_wdata} <= {2'b11, a, d};
    @(posedge clk);
    {cpu_cs, cpu_wr} <= 2'b00;
    if (!hw_mode && a == 8'h31) m31 = d;
    if (!hw_mode && a == 8'h32) m32 = d & LICB_CMI_MONITOR_MASK;
    if (!hw_mode && a == 8'h33) m33 = d;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    {cpu_cs, cpu_rd, cpu_addr} <= {2'b11, a};
    @(posedge clk);
    {cpu_cs, cpu_rd} <= 2'b00;
    @(posedge clk);
    check(32'(cpu_rdata), 32'(eff(a)));
  endtask : rd

  task automatic chk_dec();
    logic [7:0] r, c, t, ext, o;
    logic       bz, cc;
    licb_tx_s   etx;
    licb_rx_s   erx;
    repeat (3) @(posedge clk);
    {r, c, t} = {eff(8'h31), eff(8'h32), eff(8'h33)};
    {bz, cc} = {line_ctrl_buildout == 3'h0, composite_clock_mode};
    ext = c[5] ? LICB_OHM_133 : LICB_OHM_120;
    o = OHM[t[2:0]];
    if (o == 8'h00 || (t[2:0] == 3'h5 && !c[5])) o = ext;
    etx = '{r[0] & bz, r[0] & !bz, !(e1_mode & r[1]), !r[4] & !cc, !r[4] & cc, c[0], c[7],
            c[6], OHM[t[5:3]] != 8'h00, OHM[t[5:3]]};
    erx = '{cc & r[2], cc ? 6'h00 : GAIN[c[4:3]], c[5], o != ext, o};
    check(32'(tx_ctrl), 32'(etx));
    check(32'(rx_ctrl), 32'(erx));
    check(32'(clk_ctrl), 32'({r[7], r[7], r[3], t[7:6]}));
    check(32'(cmi_rx_out), 32'(rx_prev ^ (c[7] & c[6])));
    check(32'(cmi_tx_out), 32'(tx_prev ^ (c[7] & c[6])));
  endtask : chk_dec

  task automatic burst(input logic [7:0] d, input int nr, input int nv);
    int r = 0;
    int q = 0;
    wr(8'h31, d);
    repeat (12)
    begin
      @(posedge clk);
      r += (line_iface_reset_pulse === 1'b1);
      q += (tx_violation === 1'b1);
    end
    check(32'(r), 32'(nr));
    check(32'(q), 32'(nv));
  endtask : burst

  always @(posedge clk)
  begin
    rx_prev <= cmi_rx_in;
    tx_prev <= cmi_tx_in;
    cmi_tx_in <= seed[7] ^ cycles[0];
    cycles++;
    if (cycles > 4000)
    begin
      fail_count++;
      end_sim();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk_dec();
    for (int a = 8'h30; a < 8'h35; a++) rd(8'(a));
    repeat (40)
    begin
      v = rnd();
      {e1_mode, composite_clock_mode, line_ctrl_buildout} <= {v[9:8], v[12:10] & {3{v[13]}}};
      ad = 8'h30 + 8'(v[2:0] % 3'h5);
      wr(ad, v[31:24] & (ad == 8'h31 ? 8'h9F : ad == 8'h32 ? 8'hF9 : 8'hFF));
      chk_dec();
      rd(8'h31 + 8'(v[15:14]));
    end
    repeat (2)
    begin
      v = rnd();
      {hw_mode, hw_tx_alarm_pin, hw_jitter_clk_lo_pin, hw_mclk_prescale_pin} <= {1'b1, v[3:0]};
      @(posedge clk);
      wr(8'h33, v[15:8]);
      chk_dec();
      rd(8'h31);
      rd(8'h33);
      hw_mode <= 1'b0;
      chk_dec();
      rd(8'h33);
    end
    wr(8'h33, 8'h00);
    marks_only <= 1'b1;
    burst(8'h40, 1, 0);
    burst(8'h40, 0, 0);
    burst(8'h00, 0, 0);
    burst(8'h40, 1, 0);
    burst(8'h60, 0, 1);
    burst(8'h60, 0, 0);
    slow <= 1'b1;
    burst(8'h00, 0, 0);
    burst(8'h20, 0, 1);
    end_sim();
  end
endmodule : test_line_interface_control_bank
